// ===== src/amg_regs.sv
`timescale 1ns/1ps
module amg_regs
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        power_down_pin_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             left_aux_b_mute,
  output logic             right_aux_b_mute,
  output logic [4:0]       left_aux_b_gain_code,
  output logic [4:0]       right_aux_b_gain_code,
  output logic             left_aux_c_mute,
  output logic             right_aux_c_mute,
  output logic [4:0]       left_aux_c_gain_code,
  output logic [4:0]       right_aux_c_gain_code
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic        pdn_n_level;     // Filtered power-down pin
  logic [15:0] ctrl0_ff;        // Conversion-disable control
  logic [15:0] ctrl27_ff;       // Analog enable control
  logic [15:0] nxt_ctrl0;
  logic [15:0] nxt_ctrl27;
  logic [15:0] mix_ff [2];      // Aux2 and aux3 mixer registers
  logic [15:0] nxt_mix [2];
  logic        hold_mix;        // Mixer registers forced to default

  // Write channel state
  logic        aw_have_ff;      // Address captured
  logic        w_have_ff;       // Data captured
  logic [5:0]  aw_idx_ff;       // Captured register index
  logic [31:0] wdata_ff;        // Captured write data
  logic [3:0]  wstrb_ff;        // Captured byte strobes
  logic        awready_ff;
  logic        wready_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        nxt_aw_have;
  logic        nxt_w_have;
  logic [5:0]  nxt_aw_idx;
  logic [31:0] nxt_wdata;
  logic [3:0]  nxt_wstrb;
  logic        nxt_awready;
  logic        nxt_wready;
  logic        nxt_bvalid;
  logic [1:0]  nxt_bresp;
  logic        do_write;        // Both halves held, commit now

  // Read channel state
  logic        arready_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        nxt_arready;
  logic        nxt_rvalid;
  logic [31:0] nxt_rdata;
  logic [1:0]  nxt_rresp;
  logic [5:0]  ar_idx;          // Read register index

  // ---------------------------------------------------------------
  // Byte-lane merge of a 16-bit register
  // ---------------------------------------------------------------
  function automatic logic [15:0] merge16
  (
    input logic [15:0] old_val,
    input logic [31:0] data,
    input logic [3:0]  strb,
    input logic [15:0] wmask
  );
    logic [15:0] res;
    res = old_val;
    if (strb[0])
    begin
      res[7:0] = data[7:0];
    end
    if (strb[1])
    begin
      res[15:8] = data[15:8];
    end
    // Reserved bits always store zero
    merge16 = res & wmask;
  endfunction

  // ---------------------------------------------------------------
  // Power-down pin synchroniser
  // ---------------------------------------------------------------
  amg_pin_filter
  #(
    .RST_LEVEL (amg_pkg::AMG_PDN_RST)
  )
  amg_pin_filter_i
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    (power_down_pin_n),
    .level_out (pdn_n_level)
  );

  // ---------------------------------------------------------------
  // Hold condition for the mixer registers
  // ---------------------------------------------------------------
  always_comb
  begin
    hold_mix = 1'b0;
    if (!pdn_n_level)
    begin
      hold_mix = 1'b1;
    end
    if (ctrl0_ff[amg_pkg::AMG_CONV_DIS_BIT])
    begin
      hold_mix = 1'b1;
    end
    if (!ctrl27_ff[amg_pkg::AMG_MIX_EN_BIT] ||
        !ctrl27_ff[amg_pkg::AMG_CHAN_EN_BIT])
    begin
      hold_mix = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Write channel: capture address and data in either order
  // ---------------------------------------------------------------
  assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;

  always_comb
  begin
    nxt_aw_have = aw_have_ff;
    nxt_w_have  = w_have_ff;
    nxt_aw_idx  = aw_idx_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_awready = awready_ff;
    nxt_wready  = wready_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    // Address handshake
    if (s_axi_awvalid && awready_ff)
    begin
      nxt_aw_have = 1'b1;
      nxt_aw_idx  = s_axi_awaddr[7:2];
      nxt_awready = 1'b0;
    end
    // Data handshake
    if (s_axi_wvalid && wready_ff)
    begin
      nxt_w_have = 1'b1;
      nxt_wdata  = s_axi_wdata;
      nxt_wstrb  = s_axi_wstrb;
      nxt_wready = 1'b0;
    end
    // Commit and raise the response
    if (do_write)
    begin
      nxt_bvalid = 1'b1;
      case (aw_idx_ff)
        amg_pkg::AMG_IDX_CTRL0,
        amg_pkg::AMG_IDX_AUX2,
        amg_pkg::AMG_IDX_AUX3,
        amg_pkg::AMG_IDX_CTRL27,
        amg_pkg::AMG_IDX_STATUS: nxt_bresp = amg_pkg::AMG_RESP_OKAY;
        default:                 nxt_bresp = amg_pkg::AMG_RESP_SLVERR;
      endcase
    end
    // Response taken, reopen both channels
    if (bvalid_ff && s_axi_bready)
    begin
      nxt_bvalid  = 1'b0;
      nxt_aw_have = 1'b0;
      nxt_w_have  = 1'b0;
      nxt_awready = 1'b1;
      nxt_wready  = 1'b1;
    end
  end

  // Register write channel state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      aw_idx_ff  <= 6'h00;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= amg_pkg::AMG_RESP_OKAY;
    end
    else
    begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff  <= nxt_w_have;
      aw_idx_ff  <= nxt_aw_idx;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
    end
  end

  // ---------------------------------------------------------------
  // Control registers 0 and 27
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_ctrl0  = ctrl0_ff;
    nxt_ctrl27 = ctrl27_ff;
    if (do_write && aw_idx_ff == amg_pkg::AMG_IDX_CTRL0)
    begin
      nxt_ctrl0 = merge16(ctrl0_ff, wdata_ff, wstrb_ff,
                          amg_pkg::AMG_CTRL0_WMASK);
    end
    if (do_write && aw_idx_ff == amg_pkg::AMG_IDX_CTRL27)
    begin
      nxt_ctrl27 = merge16(ctrl27_ff, wdata_ff, wstrb_ff,
                           amg_pkg::AMG_CTRL27_WMASK);
    end
  end

  // Register control state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl0_ff  <= amg_pkg::AMG_CTRL0_RST;
      ctrl27_ff <= amg_pkg::AMG_CTRL27_RST;
    end
    else
    begin
      ctrl0_ff  <= nxt_ctrl0;
      ctrl27_ff <= nxt_ctrl27;
    end
  end

  // ---------------------------------------------------------------
  // Mixer registers, one per auxiliary input
  // ---------------------------------------------------------------
  for (genvar gi = 0; gi < 2; gi++)
  begin : g_mix
    // Index of this mixer register
    localparam logic [5:0] IDX = (gi == 0) ? amg_pkg::AMG_IDX_AUX2
                                           : amg_pkg::AMG_IDX_AUX3;

    // Default while held, else take accepted writes
    always_comb
    begin
      nxt_mix[gi] = mix_ff[gi];
      if (hold_mix)
      begin
        nxt_mix[gi] = amg_pkg::AMG_MIX_RST;
      end
      else if (do_write && aw_idx_ff == IDX)
      begin
        nxt_mix[gi] = merge16(mix_ff[gi], wdata_ff, wstrb_ff,
                              amg_pkg::AMG_MIX_WMASK);
      end
    end

    // Register the mixer word
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        mix_ff[gi] <= amg_pkg::AMG_MIX_RST;
      end
      else
      begin
        mix_ff[gi] <= nxt_mix[gi];
      end
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  assign ar_idx = s_axi_araddr[7:2];

  always_comb
  begin
    nxt_arready = arready_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    // Address taken, load data
    if (s_axi_arvalid && arready_ff)
    begin
      nxt_arready = 1'b0;
      nxt_rvalid  = 1'b1;
      nxt_rresp   = amg_pkg::AMG_RESP_OKAY;
      case (ar_idx)
        amg_pkg::AMG_IDX_CTRL0:  nxt_rdata = {16'h0000, ctrl0_ff};
        amg_pkg::AMG_IDX_AUX2:   nxt_rdata = {16'h0000, mix_ff[0]};
        amg_pkg::AMG_IDX_AUX3:   nxt_rdata = {16'h0000, mix_ff[1]};
        amg_pkg::AMG_IDX_CTRL27: nxt_rdata = {16'h0000, ctrl27_ff};
        amg_pkg::AMG_IDX_STATUS:
        begin
          nxt_rdata = 32'h00000000;
          nxt_rdata[amg_pkg::AMG_STAT_HOLD_BIT] = hold_mix;
          nxt_rdata[amg_pkg::AMG_STAT_PDN_BIT]  = pdn_n_level;
        end
        default:
        begin
          nxt_rdata = 32'h00000000;
          nxt_rresp = amg_pkg::AMG_RESP_SLVERR;
        end
      endcase
    end
    // Data taken, reopen address channel
    if (rvalid_ff && s_axi_rready)
    begin
      nxt_rvalid  = 1'b0;
      nxt_arready = 1'b1;
    end
  end

  // Register read channel state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= amg_pkg::AMG_RESP_OKAY;
    end
    else
    begin
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // Aux2 mute and gain straight from the stored word
  assign left_aux_b_mute  = mix_ff[0][amg_pkg::AMG_MUTE_L_BIT];
  assign right_aux_b_mute = mix_ff[0][amg_pkg::AMG_MUTE_R_BIT];
  assign left_aux_b_gain_code  =
    mix_ff[0][amg_pkg::AMG_GAIN_L_LSB +: amg_pkg::AMG_GAIN_W];
  assign right_aux_b_gain_code =
    mix_ff[0][amg_pkg::AMG_GAIN_R_LSB +: amg_pkg::AMG_GAIN_W];

  // Aux3 mute and gain straight from the stored word
  assign left_aux_c_mute  = mix_ff[1][amg_pkg::AMG_MUTE_L_BIT];
  assign right_aux_c_mute = mix_ff[1][amg_pkg::AMG_MUTE_R_BIT];
  assign left_aux_c_gain_code  =
    mix_ff[1][amg_pkg::AMG_GAIN_L_LSB +: amg_pkg::AMG_GAIN_W];
  assign right_aux_c_gain_code =
    mix_ff[1][amg_pkg::AMG_GAIN_R_LSB +: amg_pkg::AMG_GAIN_W];

endmodule

// ===== include/amg_pkg.sv
// ---------------------------------------------------------------
// Constants for the auxiliary mixer gain register bank
// ---------------------------------------------------------------
package amg_pkg;

  // Bus widths
  localparam int unsigned AMG_DATA_W  = 32;
  localparam int unsigned AMG_ADDR_W  = 8;
  localparam int unsigned AMG_IDX_W   = 6;
  localparam int unsigned AMG_REG_W   = 16;
  localparam int unsigned AMG_GAIN_W  = 5;

  // Register indices; byte address is four times the index
  localparam logic [5:0] AMG_IDX_CTRL0  = 6'h00;
  localparam logic [5:0] AMG_IDX_AUX2   = 6'h05;
  localparam logic [5:0] AMG_IDX_AUX3   = 6'h06;
  localparam logic [5:0] AMG_IDX_CTRL27 = 6'h1B;
  localparam logic [5:0] AMG_IDX_STATUS = 6'h1F;

  // Mixer register fields
  localparam int unsigned AMG_MUTE_L_BIT = 15;
  localparam int unsigned AMG_GAIN_L_LSB = 8;
  localparam int unsigned AMG_MUTE_R_BIT = 7;
  localparam int unsigned AMG_GAIN_R_LSB = 0;

  // Writable bits of a mixer register; reserved bits stay zero
  localparam logic [15:0] AMG_MIX_WMASK = 16'h9F9F;
  // Mixer reset value: both muted, both gains at 0 dB
  localparam logic [15:0] AMG_MIX_RST   = 16'h8888;

  // Control register 0 field and reset value
  localparam int unsigned AMG_CONV_DIS_BIT = 15;
  localparam logic [15:0] AMG_CTRL0_WMASK  = 16'h8000;
  localparam logic [15:0] AMG_CTRL0_RST    = 16'h0000;

  // Control register 27 fields and reset value
  localparam int unsigned AMG_MIX_EN_BIT   = 1;
  localparam int unsigned AMG_CHAN_EN_BIT  = 0;
  localparam logic [15:0] AMG_CTRL27_WMASK = 16'h0003;
  localparam logic [15:0] AMG_CTRL27_RST   = 16'h0000;

  // Status register fields
  localparam int unsigned AMG_STAT_HOLD_BIT = 0;
  localparam int unsigned AMG_STAT_PDN_BIT  = 1;

  // AXI response codes
  localparam logic [1:0] AMG_RESP_OKAY   = 2'h0;
  localparam logic [1:0] AMG_RESP_SLVERR = 2'h2;

  // Reset level of the filtered power-down pin (powered down)
  localparam logic AMG_PDN_RST = 1'b0;

endpackage

// ===== src/amg_pin_filter.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ---------------------------------------------------------------
module amg_pin_filter
#(
  parameter logic RST_LEVEL = 1'b0
)
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin_in,
  output logic      level_out
);

  logic meta_ff;   // First stage, read only by second
  logic sync_ff;   // Second stage
  logic last_ff;   // Third stage
  logic level_ff;  // Accepted level
  logic nxt_level;

  // Accept a change once second and third stages agree
  always_comb
  begin
    nxt_level = level_ff;
    if (sync_ff == last_ff)
    begin
      nxt_level = last_ff;
    end
  end

  // Register stages
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_ff  <= RST_LEVEL;
      sync_ff  <= RST_LEVEL;
      last_ff  <= RST_LEVEL;
      level_ff <= RST_LEVEL;
    end
    else
    begin
      meta_ff  <= pin_in;
      sync_ff  <= meta_ff;
      last_ff  <= sync_ff;
      level_ff <= nxt_level;
    end
  end

  assign level_out = level_ff;

endmodule

// ===== test/amg_regs_checker.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port checks for the mixer gain register bank
// ---------------------------------------------------------------
module amg_regs_checker
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        power_down_pin_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        left_aux_b_mute,
  input wire logic        right_aux_b_mute,
  input wire logic [4:0]  left_aux_b_gain_code,
  input wire logic [4:0]  right_aux_b_gain_code,
  input wire logic        left_aux_c_mute,
  input wire logic        right_aux_c_mute,
  input wire logic [4:0]  left_aux_c_gain_code,
  input wire logic [4:0]  right_aux_c_gain_code
);
  // Both mixers muted at 0 dB
  localparam logic [23:0] MIX_DFLT = 24'hA28A28;
  // All mixer outputs in one word
  logic [23:0]            mix;
  assign mix = {left_aux_b_mute, left_aux_b_gain_code, right_aux_b_mute,
    right_aux_b_gain_code, left_aux_c_mute, left_aux_c_gain_code,
    right_aux_c_mute, right_aux_c_gain_code};

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_rst_mix_default: assert property (disable iff (1'b0)
    !aresetn |=> mix == MIX_DFLT) else $error("mixer not default");
  a_pin_hold_default: assert property (
    !power_down_pin_n [*6] |=> mix == MIX_DFLT)
    else $error("power down did not hold default");
  a_mix_change_cause: assert property (
    $changed(mix) |-> $rose(s_axi_bvalid) || mix == MIX_DFLT)
    else $error("mixer changed without write");
  a_rdata_resv_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000
      && s_axi_rdata[14:13] == 2'h0 && s_axi_rdata[6:5] == 2'h0)
    else $error("reserved read bits set");
  a_b_follows_wr: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_wr_blocked: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write ready early");
  a_r_follows_ar: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read data late");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready early");
endmodule

bind amg_regs amg_regs_checker amg_regs_checker_i (.aclk, .aresetn,
  .power_down_pin_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .left_aux_b_mute, .right_aux_b_mute,
  .left_aux_b_gain_code, .right_aux_b_gain_code, .left_aux_c_mute,
  .right_aux_c_mute, .left_aux_c_gain_code, .right_aux_c_gain_code);

// ===== test/amg_regs_tb.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bench for the mixer gain register bank
// ---------------------------------------------------------------
module amg_regs_tb;
  // Byte addresses and shorthand values
  localparam logic [7:0]  A_C0  = {amg_pkg::AMG_IDX_CTRL0, 2'b00};
  localparam logic [7:0]  A_B   = {amg_pkg::AMG_IDX_AUX2, 2'b00};
  localparam logic [7:0]  A_C   = {amg_pkg::AMG_IDX_AUX3, 2'b00};
  localparam logic [7:0]  A_C27 = {amg_pkg::AMG_IDX_CTRL27, 2'b00};
  localparam logic [7:0]  A_ST  = {amg_pkg::AMG_IDX_STATUS, 2'b00};
  localparam logic [15:0] RST   = amg_pkg::AMG_MIX_RST;
  localparam logic [15:0] M     = amg_pkg::AMG_MIX_WMASK;
  localparam logic [1:0]  OK    = amg_pkg::AMG_RESP_OKAY;
  localparam logic [1:0]  ERR   = amg_pkg::AMG_RESP_SLVERR;
  // Design signals
  logic        aclk, aresetn, power_down_pin_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        left_aux_b_mute, right_aux_b_mute;
  logic        left_aux_c_mute, right_aux_c_mute;
  logic [4:0]  left_aux_b_gain_code, right_aux_b_gain_code;
  logic [4:0]  left_aux_c_gain_code, right_aux_c_gain_code;
  // Counters and stimulus table
  int          failures, checks, i;
  logic [15:0] b, c;
  logic [15:0] vals [4] = '{16'hFFFF, 16'h0000, 16'h1F1F, 16'h6A65};

  amg_regs amg_regs_i (.aclk, .aresetn, .power_down_pin_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .left_aux_b_mute, .right_aux_b_mute,
    .left_aux_b_gain_code, .right_aux_b_gain_code, .left_aux_c_mute,
    .right_aux_c_mute, .left_aux_c_gain_code, .right_aux_c_gain_code);

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  // Compare and count
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Verdict and end of run
  task close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Write; response taken a cycle late to exercise stalling
  task wr(input logic [7:0] a, input logic [15:0] d,
          input logic [3:0] s, input logic [1:0] er);
    logic done;
    done = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        done = 1'b1;
        chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, s_axi_bresp});
      end
      else if (s_axi_bvalid)
        s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
  endtask

  // Read and compare; data taken a cycle late
  task rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
    logic done;
    done = 1'b0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        done = 1'b1;
        chk($sformatf("rdata %h", a), {16'h0000, e}, s_axi_rdata);
        chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, s_axi_rresp});
      end
      else if (s_axi_rvalid)
        s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
  endtask

  // Mixer outputs laid out as register images
  task chk_mix(input logic [15:0] eb, input logic [15:0] ec);
    chk("aux_b_out", {16'h0000, eb}, {16'h0000, left_aux_b_mute, 2'b00,
      left_aux_b_gain_code, right_aux_b_mute, 2'b00, right_aux_b_gain_code});
    chk("aux_c_out", {16'h0000, ec}, {16'h0000, left_aux_c_mute, 2'b00,
      left_aux_c_gain_code, right_aux_c_mute, 2'b00, right_aux_c_gain_code});
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog, sequence
  // ---------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Hang guard, well past the expected run
  initial
  begin
    repeat (5000) @(posedge aclk);
    failures++;
    $display("mismatch watchdog expected done seen hang");
    close_out;
  end

  initial
  begin
    failures = 0;
    checks = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    {s_axi_wdata, s_axi_wstrb} = 36'h0;
    power_down_pin_n = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    chk_mix(RST, RST);
    rd(A_B, RST, OK);
    rd(A_C, RST, OK);
    // Writes refused while either enable is clear
    for (i = 0; i < 3; i++)
    begin
      wr(A_C27, i[15:0], 4'hF, OK);
      wr(A_C, 16'h0000, 4'hF, OK);
      rd(A_C, RST, OK);
    end
    wr(A_C27, 16'h0003, 4'hF, OK);
    rd(A_ST, 16'h0002, OK);
    // Field table, reserved bits always written as zero
    for (i = 0; i < 4; i++)
    begin
      b = vals[i] & M;
      c = ~vals[i] & M;
      wr(A_B, b, 4'hF, OK);
      wr(A_C, c, 4'hF, OK);
      rd(A_B, b, OK);
      rd(A_C, c, OK);
      chk_mix(b, c);
    end
    // Low lane only
    wr(A_B, 16'h9F9F, 4'h1, OK);
    rd(A_B, {b[15:8], 8'h9F}, OK);
    wr(8'h40, 16'hFFFF, 4'hF, ERR);
    rd(8'h40, 16'h0000, ERR);
    wr(A_ST, 16'hFFFF, 4'hF, OK);
    rd(A_ST, 16'h0002, OK);
    // Conversion disable forces default
    wr(A_C0, 16'h8000, 4'hF, OK);
    chk_mix(RST, RST);
    wr(A_B, 16'h0000, 4'hF, OK);
    rd(A_B, RST, OK);
    rd(A_ST, 16'h0003, OK);
    wr(A_C0, 16'h0000, 4'hF, OK);
    wr(A_B, 16'h0000, 4'hF, OK);
    rd(A_B, 16'h0000, OK);
    // Power-down pin forces default
    power_down_pin_n <= 1'b0;
    repeat (8) @(posedge aclk);
    chk_mix(RST, RST);
    rd(A_ST, 16'h0001, OK);
    wr(A_C, 16'h1111, 4'hF, OK);
    rd(A_C, RST, OK);
    power_down_pin_n <= 1'b1;
    repeat (8) @(posedge aclk);
    wr(A_C, 16'h1111, 4'hF, OK);
    rd(A_C, 16'h1111, OK);
    // Reset in mid-run
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    chk_mix(RST, RST);
    rd(A_C27, 16'h0000, OK);
    close_out;
  end
endmodule
